// file: rtl/pmr_map.svh
/*
 File holds the constants of the power mode and reset sequencer: register
 offsets, field positions, reset values, encodings and timing counts.
 Assumes a 25 MHz system clock; included by bare name, definitions only.
*/
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH

// ----------------------------------------------------------------
// Register map (byte offsets on the Avalon-MM slave)
// ----------------------------------------------------------------
`define PMR_OFS_OSC_CTRL 4'h0
`define PMR_OFS_STATUS 4'h4
`define PMR_OFS_MODE 4'h8

// Oscillator control register fields
`define PMR_F_HSEL 0
`define PMR_F_STOPH 1
`define PMR_F_OPERATING_MODE_FIELD_LO 2
`define PMR_F_OPERATING_MODE_FIELD_HI 3
`define PMR_F_LCK_T0 4

// Status register fields (timeout and power-down flags, active low)
`define PMR_F_PD_N 3
`define PMR_F_TO_N 4

// Operating mode field encodings
`define PMR_OPERATING_MODE_FIELD_RUN 2'h0
`define PMR_OPERATING_MODE_FIELD_HALT 2'h1
`define PMR_OPERATING_MODE_FIELD_STANDBY 2'h2

// Mode status encodings
`define PMR_MODE_NORMAL 2'h0
`define PMR_MODE_SLOW 2'h1
`define PMR_MODE_STANDBY 2'h2
`define PMR_MODE_HALT 2'h3

// Reset values
`define PMR_RST_STOPH 1'b0
`define PMR_RST_OPERATING_MODE_FIELD 2'h0
`define PMR_RST_LCK_T0 1'b0
`define PMR_RST_FLAG 1'b1

// Interrupt vector taken after a wake-up with interrupts enabled
`define PMR_IRQ_VECTOR 12'h008

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMR_CLK_MHZ 25
`define PMR_CNT_W 23
`define PMR_T_PWRUP0_US 140
`define PMR_T_PWRUP1_US 4500
`define PMR_T_PWRUP2_US 18000
`define PMR_T_PWRUP3_US 72000
`define PMR_T_PWRUP4_US 288000
`define PMR_PWRUP0_CYC (`PMR_T_PWRUP0_US * `PMR_CLK_MHZ)
`define PMR_OST_SHORT_CYC 1
`define PMR_OST_LONG_CYC 16
`define PMR_WAKE_XTAL_CYC 512
`define PMR_WAKE_RC_CYC 16

`endif

// file: rtl/pmr_pkg.sv
/*
 File holds the types of the power mode and reset sequencer.
 Assumes nothing of its surroundings.
*/
package pmr_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      PMR_ST_HOLD = 3'b000,
      PMR_ST_PWRUP = 3'b001,
      PMR_ST_OSC_START = 3'b010,
      PMR_ST_RUN = 3'b011,
      PMR_ST_STANDBY = 3'b100,
      PMR_ST_HALT = 3'b101,
      PMR_ST_WAKE = 3'b110
   } pmr_state_t;

endpackage

// file: rtl/pmr_sequencer.sv
/*
 File holds the power mode and reset sequencer: operating mode control,
 oscillator gating, wake-up handling and the reset sequence, with its
 control and status registers on an Avalon-MM slave.
 Assumes wake-up events, instruction strobes and the watchdog reset come
 from logic on CLK; reset detectors and the reset pin are asynchronous.
*/
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pmr_map.svh"

module pmr_sequencer
   import pmr_pkg::*;
#(
   parameter logic [`PMR_CNT_W-1:0] PWRUP1_CYC = `PMR_CNT_W'(`PMR_T_PWRUP1_US * `PMR_CLK_MHZ),
   parameter logic [`PMR_CNT_W-1:0] PWRUP2_CYC = `PMR_CNT_W'(`PMR_T_PWRUP2_US * `PMR_CLK_MHZ),
   parameter logic [`PMR_CNT_W-1:0] PWRUP3_CYC = `PMR_CNT_W'(`PMR_T_PWRUP3_US * `PMR_CLK_MHZ),
   parameter logic [`PMR_CNT_W-1:0] PWRUP4_CYC = `PMR_CNT_W'(`PMR_T_PWRUP4_US * `PMR_CLK_MHZ)
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Reset sources (detectors and pin are asynchronous)
   input wire logic POWER_ON_DETECT,
   input wire logic LOW_VOLTAGE_RESET,
   input wire logic EXTERNAL_RESET_PIN_N,
   input wire logic WDT_TIMEOUT_RESET,
   // Configuration word
   input wire logic CFG_STARTUP_FAST,
   input wire logic CFG_EXT_HIGH_CRYSTAL_OPTION,
   input wire logic CFG_EXT_CRYSTAL_OPTION,
   input wire logic CFG_EXT_LOW_CRYSTAL_OPTION,
   input wire logic [2:0] CFG_PWRUP_SEL,
   input wire logic CFG_TIMER0_LOW_SRC,
   // Core strobes and state
   input wire logic SLEEP_INSTR,
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic GLOBAL_IRQ_ENABLE,
   // Wake-up events
   input wire logic TMR0_OVERFLOW,
   input wire logic TMR1_UNDERFLOW,
   input wire logic TMR2_UNDERFLOW,
   input wire logic TMR3_UNDERFLOW,
   input wire logic CCP_IRQ,
   input wire logic WDT_TIMEOUT_IRQ,
   input wire logic PORT_CHANGE_IRQ,
   input wire logic EXTERNAL_IRQ0,
   input wire logic EXTERNAL_IRQ1,
   input wire logic LVD_IRQ,
   input wire logic CMP_IRQ,
   input wire logic ADC_DONE_IRQ,
   // Clock and power control
   output logic SYS_CLK_HIGH,
   output logic HIGH_OSC_EN,
   output logic LOW_OSC_EN,
   output logic TIMER0_LOW_CLK,
   output logic TIMER_RUN_EN,
   output logic PERIPH_EN,
   output logic CPU_RUN,
   output logic CORE_RESET_N,
   output logic [1:0] MODE,
   // Core handshakes and flags
   output logic WDT_CLEAR,
   output logic WAKE_IRQ_BRANCH,
   output logic WAKE_CONTINUE,
   output logic [11:0] BRANCH_VECTOR,
   output logic TIMEOUT_FLAG_N,
   output logic POWER_DOWN_FLAG_N
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] por_sync_r, por_sync_nxt;
   logic [1:0] lvr_sync_r, lvr_sync_nxt;
   logic [1:0] pin_sync_r, pin_sync_nxt;

   // Two stages each; only the second stage is read by logic
   always_comb begin
      por_sync_nxt = {por_sync_r[0], POWER_ON_DETECT};
      lvr_sync_nxt = {lvr_sync_r[0], LOW_VOLTAGE_RESET};
      pin_sync_nxt = {pin_sync_r[0], EXTERNAL_RESET_PIN_N};
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         por_sync_r <= 2'h0;
         lvr_sync_r <= 2'h0;
         pin_sync_r <= 2'h3;
      end else begin
         por_sync_r <= por_sync_nxt;
         lvr_sync_r <= lvr_sync_nxt;
         pin_sync_r <= pin_sync_nxt;
      end
   end

   logic por_lvr;
   logic pin_rst;
   logic reset_evt;
   assign por_lvr = por_sync_r[1] | lvr_sync_r[1];
   assign pin_rst = ~pin_sync_r[1];
   assign reset_evt = por_lvr | pin_rst | WDT_TIMEOUT_RESET;

   // ----------------------------------------------------------------
   // Wake sources and wait lengths
   // ----------------------------------------------------------------
   logic halt_wake;
   logic stby_wake;
   logic any_xtal;
   logic [`PMR_CNT_W-1:0] pwrup_target;
   logic [`PMR_CNT_W-1:0] ost_target;
   logic [`PMR_CNT_W-1:0] wake_target;

   // Halt keeps only the few sources that need no clock to be seen
   assign halt_wake = WDT_TIMEOUT_IRQ | PORT_CHANGE_IRQ | EXTERNAL_IRQ0 | EXTERNAL_IRQ1;
   assign stby_wake = halt_wake | TMR0_OVERFLOW | TMR1_UNDERFLOW | TMR2_UNDERFLOW
      | TMR3_UNDERFLOW | CCP_IRQ | LVD_IRQ | CMP_IRQ | ADC_DONE_IRQ;
   assign any_xtal = CFG_EXT_HIGH_CRYSTAL_OPTION | CFG_EXT_CRYSTAL_OPTION
      | CFG_EXT_LOW_CRYSTAL_OPTION;
   assign wake_target = any_xtal ? `PMR_CNT_W'(`PMR_WAKE_XTAL_CYC)
                                 : `PMR_CNT_W'(`PMR_WAKE_RC_CYC);
   assign ost_target = (CFG_PWRUP_SEL == 3'h0) ? `PMR_CNT_W'(`PMR_OST_SHORT_CYC)
                                               : `PMR_CNT_W'(`PMR_OST_LONG_CYC);

   // Power-up time select; codes above four all give the longest time
   always_comb begin
      case (CFG_PWRUP_SEL)
         3'h0: pwrup_target = `PMR_CNT_W'(`PMR_PWRUP0_CYC);
         3'h1: pwrup_target = PWRUP1_CYC;
         3'h2: pwrup_target = PWRUP2_CYC;
         3'h3: pwrup_target = PWRUP3_CYC;
         default: pwrup_target = PWRUP4_CYC;
      endcase
   end

   // ----------------------------------------------------------------
   // Bus slave: one wait state, then the answer
   // ----------------------------------------------------------------
   logic waitreq_r, waitreq_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic bus_wr;
   logic hsel_r, stoph_r, lck_r, to_n_r, pd_n_r;
   logic [1:0] operating_mode_field_r;
   logic [1:0] mode_r;

   assign bus_wr = AVS_WRITE & ~waitreq_r;

   // Read data is captured while waitrequest is high, so it stands at the answer edge
   always_comb begin
      waitreq_nxt = ~((AVS_READ | AVS_WRITE) & waitreq_r);
      rdata_nxt = rdata_r;
      if (AVS_READ && waitreq_r) begin
         case (AVS_ADDRESS)
            `PMR_OFS_OSC_CTRL: rdata_nxt = {27'h0, lck_r, operating_mode_field_r, stoph_r, hsel_r};
            `PMR_OFS_STATUS: rdata_nxt = {27'h0, to_n_r, pd_n_r, 3'h0};
            `PMR_OFS_MODE: rdata_nxt = {30'h0, mode_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         waitreq_r <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         waitreq_r <= waitreq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign AVS_WAITREQUEST = waitreq_r;
   assign AVS_READDATA = rdata_r;

   // ----------------------------------------------------------------
   // Mode and reset sequencer
   // ----------------------------------------------------------------
   pmr_state_t state_r, state_nxt;
   logic [`PMR_CNT_W-1:0] cnt_r, cnt_nxt;
   logic hsel_nxt, stoph_nxt, lck_nxt, to_n_nxt, pd_n_nxt;
   logic [1:0] operating_mode_field_nxt;
   logic gie_hold_r, gie_hold_nxt;
   logic wdt_clr_r, wdt_clr_nxt;
   logic branch_r, branch_nxt;
   logic cont_r, cont_nxt;
   logic halt_go;
   logic resume;

   assign halt_go = SLEEP_INSTR | (operating_mode_field_r == `PMR_OPERATING_MODE_FIELD_HALT);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      hsel_nxt = hsel_r;
      stoph_nxt = stoph_r;
      lck_nxt = lck_r;
      operating_mode_field_nxt = operating_mode_field_r;
      to_n_nxt = to_n_r;
      pd_n_nxt = pd_n_r;
      gie_hold_nxt = gie_hold_r;
      wdt_clr_nxt = 1'b0;
      resume = 1'b0;
      // Stop bit and mode field land together from one write
      if (bus_wr && AVS_ADDRESS == `PMR_OFS_OSC_CTRL && AVS_BYTEENABLE[0]) begin
         hsel_nxt = AVS_WRITEDATA[`PMR_F_HSEL];
         stoph_nxt = AVS_WRITEDATA[`PMR_F_STOPH];
         operating_mode_field_nxt = AVS_WRITEDATA[`PMR_F_OPERATING_MODE_FIELD_HI:`PMR_F_OPERATING_MODE_FIELD_LO];
         lck_nxt = AVS_WRITEDATA[`PMR_F_LCK_T0];
      end
      case (state_r)
         PMR_ST_HOLD: begin
            state_nxt = PMR_ST_PWRUP;
            cnt_nxt = pwrup_target - `PMR_CNT_W'(1);
         end
         PMR_ST_PWRUP: begin
            if (cnt_r == '0) begin
               state_nxt = PMR_ST_OSC_START;
               cnt_nxt = ost_target - `PMR_CNT_W'(1);
            end else begin
               cnt_nxt = cnt_r - `PMR_CNT_W'(1);
            end
         end
         PMR_ST_OSC_START: begin
            if (cnt_r == '0) begin
               state_nxt = PMR_ST_RUN;
            end else begin
               cnt_nxt = cnt_r - `PMR_CNT_W'(1);
            end
         end
         PMR_ST_RUN: begin
            if (halt_go) begin
               state_nxt = PMR_ST_HALT;
               to_n_nxt = 1'b1;
               pd_n_nxt = 1'b0;
               wdt_clr_nxt = 1'b1;
               gie_hold_nxt = GLOBAL_IRQ_ENABLE;
            end else if (operating_mode_field_r == `PMR_OPERATING_MODE_FIELD_STANDBY) begin
               state_nxt = PMR_ST_STANDBY;
               gie_hold_nxt = GLOBAL_IRQ_ENABLE;
            end else if (WATCHDOG_CLEAR_INSTR) begin
               to_n_nxt = 1'b1;
               pd_n_nxt = 1'b1;
            end
         end
         PMR_ST_STANDBY: begin
            // An oscillator never stopped, so execution resumes at once
            if (stby_wake) begin
               resume = 1'b1;
            end
         end
         PMR_ST_HALT: begin
            if (halt_wake) begin
               state_nxt = PMR_ST_WAKE;
               cnt_nxt = wake_target - `PMR_CNT_W'(1);
            end
         end
         PMR_ST_WAKE: begin
            if (cnt_r == '0) begin
               resume = 1'b1;
            end else begin
               cnt_nxt = cnt_r - `PMR_CNT_W'(1);
            end
         end
         default: state_nxt = PMR_ST_HOLD;
      endcase
      // Clearing the field keeps the block from dropping straight back in
      if (resume) begin
         state_nxt = PMR_ST_RUN;
         operating_mode_field_nxt = `PMR_OPERATING_MODE_FIELD_RUN;
      end
      // Reset events override everything and reload the registers
      if (reset_evt) begin
         state_nxt = PMR_ST_HOLD;
         hsel_nxt = CFG_STARTUP_FAST;
         stoph_nxt = `PMR_RST_STOPH;
         operating_mode_field_nxt = `PMR_RST_OPERATING_MODE_FIELD;
         lck_nxt = `PMR_RST_LCK_T0;
         wdt_clr_nxt = 1'b0;
         resume = 1'b0;
         if (por_lvr) begin
            to_n_nxt = 1'b1;
            pd_n_nxt = 1'b1;
         end else if (WDT_TIMEOUT_RESET) begin
            to_n_nxt = 1'b0;
            pd_n_nxt = (state_r != PMR_ST_HALT);
         end else if (state_r == PMR_ST_HALT) begin
            to_n_nxt = 1'b1;
            pd_n_nxt = 1'b1;
         end
      end
      branch_nxt = resume & gie_hold_r;
      cont_nxt = resume & ~gie_hold_r;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_r <= PMR_ST_HOLD;
         cnt_r <= '0;
         hsel_r <= CFG_STARTUP_FAST;
         stoph_r <= `PMR_RST_STOPH;
         operating_mode_field_r <= `PMR_RST_OPERATING_MODE_FIELD;
         lck_r <= `PMR_RST_LCK_T0;
         to_n_r <= `PMR_RST_FLAG;
         pd_n_r <= `PMR_RST_FLAG;
         gie_hold_r <= 1'b0;
         wdt_clr_r <= 1'b0;
         branch_r <= 1'b0;
         cont_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         hsel_r <= hsel_nxt;
         stoph_r <= stoph_nxt;
         operating_mode_field_r <= operating_mode_field_nxt;
         lck_r <= lck_nxt;
         to_n_r <= to_n_nxt;
         pd_n_r <= pd_n_nxt;
         gie_hold_r <= gie_hold_nxt;
         wdt_clr_r <= wdt_clr_nxt;
         branch_r <= branch_nxt;
         cont_r <= cont_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Clock and power outputs, registered in step with the state
   // ----------------------------------------------------------------
   logic run_n, stby_n, halt_n, hosc_r, hosc_nxt, losc_r, losc_nxt;
   logic t0lck_r, t0lck_nxt, tmr_r, tmr_nxt, core_rn_r, core_rn_nxt;
   logic prun_r, prun_nxt;
   logic [1:0] mode_nxt;

   // High oscillator stops in halt, and otherwise only on request once the low clock runs the core
   always_comb begin
      run_n = (state_nxt == PMR_ST_RUN);
      stby_n = (state_nxt == PMR_ST_STANDBY);
      halt_n = (state_nxt == PMR_ST_HALT);
      hosc_nxt = ~halt_n & ~((run_n | stby_n) & stoph_nxt & ~hsel_nxt);
      losc_nxt = ~halt_n;
      t0lck_nxt = lck_nxt & CFG_TIMER0_LOW_SRC & ~halt_n;
      tmr_nxt = run_n | stby_n;
      prun_nxt = run_n;
      core_rn_nxt = run_n | stby_n | halt_n | (state_nxt == PMR_ST_WAKE);
      if (halt_n || state_nxt == PMR_ST_WAKE) begin
         mode_nxt = `PMR_MODE_HALT;
      end else if (stby_n) begin
         mode_nxt = `PMR_MODE_STANDBY;
      end else begin
         mode_nxt = hsel_nxt ? `PMR_MODE_NORMAL : `PMR_MODE_SLOW;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         hosc_r <= 1'b1;
         losc_r <= 1'b1;
         t0lck_r <= 1'b0;
         tmr_r <= 1'b0;
         prun_r <= 1'b0;
         core_rn_r <= 1'b0;
         mode_r <= `PMR_MODE_NORMAL;
      end else begin
         hosc_r <= hosc_nxt;
         losc_r <= losc_nxt;
         t0lck_r <= t0lck_nxt;
         tmr_r <= tmr_nxt;
         prun_r <= prun_nxt;
         core_rn_r <= core_rn_nxt;
         mode_r <= mode_nxt;
      end
   end

   assign SYS_CLK_HIGH = hsel_r;
   assign HIGH_OSC_EN = hosc_r;
   assign LOW_OSC_EN = losc_r;
   assign TIMER0_LOW_CLK = t0lck_r;
   assign TIMER_RUN_EN = tmr_r;
   assign PERIPH_EN = prun_r;
   assign CPU_RUN = prun_r;
   assign CORE_RESET_N = core_rn_r;
   assign MODE = mode_r;
   assign WDT_CLEAR = wdt_clr_r;
   assign WAKE_IRQ_BRANCH = branch_r;
   assign WAKE_CONTINUE = cont_r;
   assign BRANCH_VECTOR = `PMR_IRQ_VECTOR;
   assign TIMEOUT_FLAG_N = to_n_r;
   assign POWER_DOWN_FLAG_N = pd_n_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [`PMR_CNT_W-1:0] seg_len_r;

   // Cycles spent so far in the current state
   always_ff @(posedge CLK) begin
      if (!RST_N || state_nxt != state_r) begin
         seg_len_r <= '0;
      end else begin
         seg_len_r <= seg_len_r + `PMR_CNT_W'(1);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_halt_entry;
      state_r == PMR_ST_RUN && halt_go && !reset_evt;
   endsequence
   sequence s_leave(pmr_state_t st);
      state_r == st && state_nxt != st && !reset_evt;
   endsequence

   AST_RESET_HOLDS_CORE: assert property (reset_evt |=> !CORE_RESET_N ##1 !CPU_RUN)
      else $error("Reset event did not hold the core");
   AST_START_MODE: assert property ($rose(CPU_RUN) && $past(state_r) == PMR_ST_OSC_START
      |-> SYS_CLK_HIGH == CFG_STARTUP_FAST)
      else $error("Start mode does not follow startup configuration");
   AST_SELECT_WRITE: assert property (bus_wr && AVS_ADDRESS == `PMR_OFS_OSC_CTRL
      && AVS_BYTEENABLE[0] && !reset_evt |=> SYS_CLK_HIGH == $past(AVS_WRITEDATA[0]))
      else $error("Clock select write not applied");
   AST_STANDBY_ENTRY: assert property (state_r == PMR_ST_RUN && !halt_go
      && operating_mode_field_r == `PMR_OPERATING_MODE_FIELD_STANDBY && !reset_evt |=> MODE == `PMR_MODE_STANDBY && !CPU_RUN)
      else $error("Standby not entered");
   AST_HALT_FLAGS: assert property (s_halt_entry |=> TIMEOUT_FLAG_N && !POWER_DOWN_FLAG_N
      && WDT_CLEAR ##1 !WDT_CLEAR)
      else $error("Halt entry flags or watchdog clear wrong");
   AST_SLOW_STOP: assert property (state_r == PMR_ST_RUN && !hsel_r && stoph_r
      |-> !HIGH_OSC_EN)
      else $error("High oscillator not stopped in slow mode");
   AST_NORMAL_CLOCKS: assert property (state_r == PMR_ST_RUN && hsel_r
      |-> HIGH_OSC_EN && LOW_OSC_EN)
      else $error("Oscillator stopped in normal mode");
   AST_HALT_OFF: assert property (state_r == PMR_ST_HALT
      |-> !HIGH_OSC_EN && !LOW_OSC_EN && !TIMER_RUN_EN && !PERIPH_EN)
      else $error("Halt left a clock or peripheral running");
   AST_HALT_STAYS: assert property (state_r == PMR_ST_HALT && !halt_wake && !reset_evt
      |=> state_r == PMR_ST_HALT)
      else $error("Halt left without a halt wake source");
   AST_STANDBY_WAKE: assert property (state_r == PMR_ST_STANDBY && stby_wake && !reset_evt
      |=> CPU_RUN && (WAKE_IRQ_BRANCH != WAKE_CONTINUE))
      else $error("Standby wake did not resume at once");
   AST_WAKE_LENGTH: assert property (s_leave(PMR_ST_WAKE)
      |-> seg_len_r + `PMR_CNT_W'(1) == wake_target)
      else $error("Halt wake wait has wrong length");
   AST_RESUME_MODE: assert property (s_leave(PMR_ST_WAKE) |=> CPU_RUN
      && MODE == (hsel_r ? `PMR_MODE_NORMAL : `PMR_MODE_SLOW))
      else $error("Resume mode does not follow clock select");
   AST_BRANCH: assert property (s_leave(PMR_ST_WAKE) |=> WAKE_IRQ_BRANCH == $past(gie_hold_r)
      && WAKE_CONTINUE == !$past(gie_hold_r))
      else $error("Wake branch choice wrong");
   AST_WDT_RESET_FLAGS: assert property (WDT_TIMEOUT_RESET && !por_lvr
      |=> !TIMEOUT_FLAG_N && POWER_DOWN_FLAG_N == ($past(state_r) != PMR_ST_HALT))
      else $error("Watchdog reset flags wrong");
   AST_PWRUP_LENGTH: assert property (s_leave(PMR_ST_PWRUP)
      |-> seg_len_r + `PMR_CNT_W'(1) == pwrup_target)
      else $error("Power-up time has wrong length");
   AST_OST_LENGTH: assert property (s_leave(PMR_ST_OSC_START)
      |-> seg_len_r + `PMR_CNT_W'(1) == ost_target)
      else $error("Start-up count has wrong length");

endmodule // pmr_sequencer

// file: sim/pmr_core_model.sv
/* Core and wake-source model facing the sequencer.
 Assumes bench requests change just after a rising CLK edge. */
`timescale 1ns/1ps
module pmr_core_model (
   // Clock and run state
   input wire logic clk,
   input wire logic cpu_run,
   // Bench requests
   input wire logic sleep_req,
   input wire logic [11:0] ev_req,
   // Strobes to the sequencer
   output logic sleep = 1'b0,
   output logic [11:0] ev = 12'h0
);
   logic [1:0] nop_r = 2'h0;
   // Two idle instructions after each resume before the next sleep
   always @(posedge clk) begin
      nop_r <= cpu_run ? nop_r + {1'b0, nop_r != 2'h2} : 2'h0;
      sleep <= sleep_req & cpu_run & (nop_r == 2'h2) & !sleep;
      ev <= ev_req;
   end
endmodule // pmr_core_model

// file: sim/tb_top.sv
/* Bench for the power mode and reset sequencer.
 Assumes only RC oscillators and short power-up counts. */
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, wdt_rst = 0, clr = 0, global_irq_enable = 0, sreq = 0;
   logic be = 1, por = 0, low_voltage_reset = 0, pin_n = 1, fast = 1, t0src = 1, xtal = 0;
   logic wq, sleep, shi, hen, len, t0l, trn, pen, run, crn, wib, wco, ton, pdn, wdc;
   logic [3:0] adr = 4'h0;
   logic [2:0] psel = 3'h1;
   logic [31:0] wd = 32'h0, rdat, rdd;
   logic [11:0] ev_req = 12'h0, ev, vec;
   logic [1:0] mode;
   int bad_count = 0, n_tests = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   pmr_sequencer #(.PWRUP1_CYC(23'd20), .PWRUP2_CYC(23'd30), .PWRUP3_CYC(23'd40),
      .PWRUP4_CYC(23'd50)) u_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE({3'h0, be}), .AVS_WRITEDATA(wd),
      .AVS_READDATA(rdd), .AVS_WAITREQUEST(wq), .POWER_ON_DETECT(por),
      .LOW_VOLTAGE_RESET(low_voltage_reset), .EXTERNAL_RESET_PIN_N(pin_n), .WDT_TIMEOUT_RESET(wdt_rst),
      .CFG_STARTUP_FAST(fast), .CFG_EXT_HIGH_CRYSTAL_OPTION(xtal),
      .CFG_EXT_CRYSTAL_OPTION(xtal), .CFG_EXT_LOW_CRYSTAL_OPTION(xtal),
      .CFG_PWRUP_SEL(psel), .CFG_TIMER0_LOW_SRC(t0src), .SLEEP_INSTR(sleep),
      .WATCHDOG_CLEAR_INSTR(clr), .GLOBAL_IRQ_ENABLE(global_irq_enable), .TMR0_OVERFLOW(ev[0]),
      .TMR1_UNDERFLOW(ev[1]), .TMR2_UNDERFLOW(ev[2]), .TMR3_UNDERFLOW(ev[3]),
      .CCP_IRQ(ev[4]), .WDT_TIMEOUT_IRQ(ev[5]), .PORT_CHANGE_IRQ(ev[6]),
      .EXTERNAL_IRQ0(ev[7]), .EXTERNAL_IRQ1(ev[8]), .LVD_IRQ(ev[9]), .CMP_IRQ(ev[10]),
      .ADC_DONE_IRQ(ev[11]), .SYS_CLK_HIGH(shi), .HIGH_OSC_EN(hen), .LOW_OSC_EN(len),
      .TIMER0_LOW_CLK(t0l), .TIMER_RUN_EN(trn), .PERIPH_EN(pen), .CPU_RUN(run),
      .CORE_RESET_N(crn), .MODE(mode), .WDT_CLEAR(wdc), .WAKE_IRQ_BRANCH(wib),
      .WAKE_CONTINUE(wco), .BRANCH_VECTOR(vec), .TIMEOUT_FLAG_N(ton),
      .POWER_DOWN_FLAG_N(pdn));
   pmr_core_model u_core (.clk(clk), .cpu_run(run), .sleep_req(sreq), .ev_req(ev_req),
      .sleep(sleep), .ev(ev));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Avalon access; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      rd <= !w; wr <= w; adr <= a; wd <= d;
      i = 0;
      do begin @(posedge clk); i++; end while (wq !== 1'b0 && i < 50);
      if (i >= 50) begin bad_count++; end_of_test(); end
      rdat = rdd;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   task automatic pulse(input int k);
      ev_req[k] <= 1'b1;
      @(posedge clk);
      ev_req[k] <= 1'b0;
   endtask
   // Bounded wait for execution to resume; cycle count returned
   task automatic wait_run(output int c);
      c = 0;
      while (run !== 1'b1 && c < 200) begin @(posedge clk); c++; end
      if (c >= 200) begin bad_count++; end_of_test(); end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      int c;
      wait_run(c);
      chk("reset run delay", 1, c >= 36 && c <= 40);
      chk("reset state", 5'h07, {mode, shi, ton, pdn});
      chk("low osc in normal", 1, len);
   endtask
   task automatic t_standby();
      int c;
      bus(1'b1, 4'h0, 32'h11);
      repeat (2) @(posedge clk);
      chk("timer0 low clock", 1, t0l);
      global_irq_enable <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         bus(1'b1, 4'h0, 32'h19);
         repeat (2) @(posedge clk);
         chk("standby state", 7'h47, {mode, run, pen, trn, len, hen});
         pulse(i);
         wait_run(c);
         chk("standby wake delay", 1, c <= 3);
         chk("standby wake", 15'h1008, {mode, wib, vec});
      end
   endtask
   task automatic t_halt();
      int c;
      global_irq_enable <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         bus(1'b1, 4'h0, 32'h5);
         repeat (2) @(posedge clk);
         chk("halt state", 7'h60, {mode, run, pen, trn, hen, len});
         chk("halt flags", 3'h5, {ton, pdn, wdc});
         pulse(i);
         if (!(i inside {[5:8]})) begin
            repeat (20) @(posedge clk);
            chk("halt held", 0, run);
            pulse(6);
         end
         wait_run(c);
         chk("halt wake delay", 1, c >= 16 && c <= 19);
         chk("halt wake", 4'h1, {mode, wib, wco});
      end
   endtask
   task automatic t_slow();
      int c;
      bus(1'b1, 4'h0, 32'h0);
      repeat (2) @(posedge clk);
      chk("slow mode", 3'h1, {shi, mode});
      bus(1'b1, 4'h0, 32'h2);
      repeat (2) @(posedge clk);
      chk("high osc stop", 0, hen);
      sreq <= 1'b1;
      repeat (4) @(posedge clk);
      sreq <= 1'b0;
      chk("sleep mode", 2'h3, mode);
      bus(1'b0, 4'h4, 32'h0);
      chk("sleep status", 32'h10, rdat & 32'h18);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped read", 0, rdat);
      pulse(7);
      wait_run(c);
      chk("slow resume", 2'h1, mode);
      bus(1'b1, 4'h0, 32'h1);
   endtask
   task automatic t_wdt();
      int c;
      wdt_rst <= 1'b1;
      @(posedge clk);
      wdt_rst <= 1'b0;
      @(posedge clk);
      chk("watchdog reset", 3'h1, {crn, ton, pdn});
      wait_run(c);
      chk("restart delay", 1, c >= 34 && c <= 40);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("watchdog clear", 2'h3, {ton, pdn});
   endtask
   // Pin reset from halt, then a second release of the bench reset
   task automatic t_pin();
      int c;
      bus(1'b1, 4'h0, 32'h5);
      repeat (2) @(posedge clk);
      pin_n <= 1'b0;
      fast <= 1'b0;
      repeat (4) @(posedge clk);
      pin_n <= 1'b1;
      wait_run(c);
      chk("pin reset from halt", 5'h0b, {mode, shi, ton, pdn});
      rst_n <= 1'b0;
      fast <= 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait_run(c);
      chk("restart after reset", 5'h07, {mode, shi, ton, pdn});
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_standby();
      t_halt();
      t_slow();
      t_wdt();
      t_pin();
      end_of_test();
   end
endmodule // tb_top
